// ---- common/fault_action_pkg.sv ----
// Constants, types and decode helpers for the current fault response control.
// Assumes one 100 MHz system clock and a command port carrying page, code and data.
// What this block does
// [RULE1] Any triggered current fault pulls alert low.
// [RULE2] Triggered fault sets its status flag always.
// [RULE3] Flags clear only on clear faults command.
// [RULE4] Response 10: disable now, then retry policy.
// [RULE5] Response 11: off only while fault persists.
// [RULE6] Retry 000: stay off until cleared.
// [RULE7] Retry 111: restart repeatedly until stopped.
// [RULE8] Retry start interval is (delay+1) times 35ms.
// [RULE9] Undercurrent byte sets the undercurrent flag.
// [RULE10] Undercurrent byte resets to 80h.
// [RULE11] One paged byte each, write protectable.
// [RULE12] Overcurrent byte resets 80h, sets overcurrent flag.
// [RULE13] Unused codes mean shutdown without any retry.
package fault_action_pkg;

	// ----------------------------------------------------------------
	// Command codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OC_ACTION_CODE = 8'he5;
	localparam logic [7:0] UC_ACTION_CODE = 8'he6;
	localparam logic [7:0] ACTION_RESET   = 8'h80;

	// ----------------------------------------------------------------
	// Field positions and encodings of an action byte
	// ----------------------------------------------------------------
	localparam int         RESP_MSB      = 7;
	localparam int         RESP_LSB      = 6;
	localparam int         RETRY_MSB     = 5;
	localparam int         RETRY_LSB     = 3;
	localparam int         DELAY_MSB     = 2;
	localparam int         DELAY_LSB     = 0;
	localparam logic [1:0] RESP_RETRY    = 2'h2;
	localparam logic [1:0] RESP_FOLLOW   = 2'h3;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_KHZ      = 100000;
	localparam int RETRY_STEP_MS     = 35;
	localparam int RETRY_STEP_CYCLES = RETRY_STEP_MS * CLK_FREQ_KHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ACT_LATCH, ACT_FOLLOW, ACT_RETRY} action_t;
	typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_FOLLOW, ST_RETRY} resp_state_t;

	// Maps an action byte to the reaction; every unused code falls back to a latched shutdown.
	function automatic action_t decode_action(input logic [7:0] act);
		if (act[RESP_MSB:RESP_LSB] == RESP_FOLLOW) begin
			decode_action = ACT_FOLLOW; // [RULE5]
		end else if (act[RESP_MSB:RESP_LSB] == RESP_RETRY && act[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER) begin
			decode_action = ACT_RETRY; // [RULE7]
		end else begin
			decode_action = ACT_LATCH; // [RULE6] [RULE13]
		end
	endfunction : decode_action

endpackage : fault_action_pkg

// ---- hdl/fault_retry_timer.sv ----
// Retry interval timer: counts (delay + 1) steps of a fixed cycle length.
// Assumes start_in is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
module fault_retry_timer #(
	parameter int STEP_CYCLES = fault_action_pkg::RETRY_STEP_CYCLES
) (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       start_in,
	input  wire logic [2:0] delay_in,
	output logic            busy_out,
	output logic            done_out
);

	localparam int CW = $clog2(STEP_CYCLES + 1);
	localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

	logic [CW-1:0] step_cnt;
	logic [CW-1:0] next_step_cnt;
	logic [2:0]    unit_cnt;
	logic [2:0]    next_unit_cnt;
	logic          next_busy;

	// Flags the last count cycle, so the owner acts on the edge that ends the interval exactly.
	assign done_out = busy_out & (step_cnt == '0) & (unit_cnt == 3'h0); // [RULE8]

	// Counts steps inside a unit, then units down to zero.
	always_comb begin
		next_step_cnt = step_cnt;
		next_unit_cnt = unit_cnt;
		next_busy     = busy_out;
		if (start_in) begin
			next_step_cnt = STEP_LAST;
			next_unit_cnt = delay_in; // [RULE8]
			next_busy     = 1'b1;
		end else if (busy_out) begin
			if (step_cnt != '0) begin
				next_step_cnt = step_cnt - 1'b1;
			end else if (unit_cnt != 3'h0) begin
				next_step_cnt = STEP_LAST;
				next_unit_cnt = unit_cnt - 3'h1;
			end else begin
				next_busy = 1'b0;
			end
		end
	end

	// Registers the timer state.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			step_cnt <= '0;
			unit_cnt <= 3'h0;
			busy_out <= 1'b0;
		end else begin
			step_cnt <= next_step_cnt;
			unit_cnt <= next_unit_cnt;
			busy_out <= next_busy;
		end
	end

endmodule : fault_retry_timer

// ---- hdl/current_fault_response_ctrl.sv ----
// Current fault response control: paged action bytes, fault flags, alert and output enables.
// Assumes fault detectors and enable command are synchronous levels per page, and bias sense is one shared synchronous level.
`timescale 1ns/1ps
module current_fault_response_ctrl #(
	parameter int PAGES       = 2,
	parameter int STEP_CYCLES = fault_action_pkg::RETRY_STEP_CYCLES
) (
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic [$clog2(PAGES)-1:0] page_in,
	input  wire logic [7:0]               cmd_code_in,
	input  wire logic                     wr_en_in,
	input  wire logic [7:0]               wr_data_in,
	input  wire logic                     rd_en_in,
	input  wire logic                     write_protect_in,
	input  wire logic                     clear_faults_in,
	input  wire logic [PAGES-1:0]         oc_fault_in,
	input  wire logic [PAGES-1:0]         uc_fault_in,
	input  wire logic [PAGES-1:0]         on_command_in,
	input  wire logic                     bias_ok_in,
	input  wire logic [PAGES-1:0]         other_shutdown_in,
	output logic [7:0]                    rd_data_out,
	output logic                          rd_valid_out,
	output logic                          wr_refused_out,
	output logic [PAGES-1:0]              oc_flag_out,
	output logic [PAGES-1:0]              uc_flag_out,
	output logic [PAGES-1:0]              output_enable_out,
	output logic                          bus_alert_out
);

	// ----------------------------------------------------------------
	// Action byte storage and command port
	// ----------------------------------------------------------------
	logic [7:0] oc_action [PAGES];
	logic [7:0] uc_action [PAGES];
	logic [7:0] next_oc_action [PAGES];
	logic [7:0] next_uc_action [PAGES];
	logic [7:0] next_rd_data;
	logic       next_rd_valid;
	logic       next_wr_refused;
	logic       hit_oc;
	logic       hit_uc;

	assign hit_oc = (cmd_code_in == fault_action_pkg::OC_ACTION_CODE);
	assign hit_uc = (cmd_code_in == fault_action_pkg::UC_ACTION_CODE);

	// Writes land in the addressed page unless protected; reads of other codes return zero.
	always_comb begin
		next_oc_action  = oc_action;
		next_uc_action  = uc_action;
		next_rd_data    = 8'h00;
		next_rd_valid   = rd_en_in;
		next_wr_refused = 1'b0;
		if (wr_en_in) begin
			if (write_protect_in) begin
				next_wr_refused = hit_oc | hit_uc; // [RULE11]
			end else if (hit_oc) begin
				next_oc_action[page_in] = wr_data_in; // [RULE11]
			end else if (hit_uc) begin
				next_uc_action[page_in] = wr_data_in; // [RULE11]
			end
		end
		if (rd_en_in) begin
			if (hit_oc) begin
				next_rd_data = oc_action[page_in];
			end else if (hit_uc) begin
				next_rd_data = uc_action[page_in];
			end
		end
	end

	// Registers the action bytes and the read answer.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < PAGES; p++) begin
				oc_action[p] <= fault_action_pkg::ACTION_RESET; // [RULE12]
				uc_action[p] <= fault_action_pkg::ACTION_RESET; // [RULE10]
			end
			rd_data_out    <= 8'h00;
			rd_valid_out   <= 1'b0;
			wr_refused_out <= 1'b0;
		end else begin
			oc_action      <= next_oc_action;
			uc_action      <= next_uc_action;
			rd_data_out    <= next_rd_data;
			rd_valid_out   <= next_rd_valid;
			wr_refused_out <= next_wr_refused;
		end
	end

	// ----------------------------------------------------------------
	// Per-page response engine
	// ----------------------------------------------------------------
	logic [PAGES-1:0] next_oc_flag;
	logic [PAGES-1:0] next_uc_flag;
	logic [PAGES-1:0] next_enable;

	genvar g;
	generate
		for (g = 0; g < PAGES; g++) begin : g_page
			fault_action_pkg::resp_state_t state;
			fault_action_pkg::resp_state_t next_state;
			fault_action_pkg::action_t     act;
			logic                          allowed;
			logic                          trip_oc;
			logic                          trip_uc;
			logic                          timer_start;
			logic                          timer_busy;
			logic                          timer_done;
			logic [2:0]                    delay;

			// The overcurrent byte takes precedence when both faults trip together.
			assign allowed = on_command_in[g] & bias_ok_in & ~other_shutdown_in[g];
			assign trip_oc = (state == fault_action_pkg::ST_RUN) & allowed & oc_fault_in[g];
			assign trip_uc = (state == fault_action_pkg::ST_RUN) & allowed & uc_fault_in[g];
			assign act     = trip_oc ? fault_action_pkg::decode_action(oc_action[g])
			                         : fault_action_pkg::decode_action(uc_action[g]);
			assign delay   = trip_oc ? oc_action[g][fault_action_pkg::DELAY_MSB:fault_action_pkg::DELAY_LSB]
			                         : uc_action[g][fault_action_pkg::DELAY_MSB:fault_action_pkg::DELAY_LSB];

			// Response state: run, latched off, following the fault, or waiting to retry.
			always_comb begin
				next_state  = state;
				timer_start = 1'b0;
				case (state)
					fault_action_pkg::ST_RUN: begin
						if (trip_oc | trip_uc) begin
							case (act)
								fault_action_pkg::ACT_FOLLOW: next_state = fault_action_pkg::ST_FOLLOW; // [RULE5]
								fault_action_pkg::ACT_RETRY: begin
									next_state  = fault_action_pkg::ST_RETRY; // [RULE4]
									// A timer in its last cycle is free again, so it restarts for this trip.
									timer_start = ~timer_busy | timer_done; // [RULE8]
								end
								default: next_state = fault_action_pkg::ST_LATCHED; // [RULE4] [RULE6] [RULE13]
							endcase
						end
					end
					fault_action_pkg::ST_LATCHED: begin
						if (clear_faults_in) begin
							next_state = fault_action_pkg::ST_RUN; // [RULE6]
						end
					end
					fault_action_pkg::ST_FOLLOW: begin
						if (!oc_fault_in[g] && !uc_fault_in[g]) begin
							next_state = fault_action_pkg::ST_RUN; // [RULE5]
						end
					end
					fault_action_pkg::ST_RETRY: begin
						if (!allowed) begin
							next_state = fault_action_pkg::ST_RUN; // [RULE7]
						end else if (timer_done) begin
							next_state  = fault_action_pkg::ST_RUN; // [RULE7]
							timer_start = 1'b1; // [RULE8]
						end
					end
					default: next_state = fault_action_pkg::ST_LATCHED;
				endcase
			end

			// Registers the response state.
			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					state <= fault_action_pkg::ST_RUN;
				end else begin
					state <= next_state;
				end
			end

			// Measures each interval from the start of one attempt to the next.
			// A trip takes the tripping byte's delay; later restarts take the armed retry byte's delay.
			fault_retry_timer #(
				.STEP_CYCLES (STEP_CYCLES)
			) u_timer (
				.sys_clk_in (sys_clk_in),
				.rst_n_in   (rst_n_in),
				.start_in   (timer_start),
				.delay_in   ((trip_oc | trip_uc) ? delay : oc_or_uc_delay(g)),
				.busy_out   (timer_busy),
				.done_out   (timer_done)
			);

			// Flags set on a trip; a trip in the clearing cycle wins over the clear.
			always_comb begin
				next_oc_flag[g] = trip_oc | (oc_flag_out[g] & ~clear_faults_in); // [RULE2] [RULE3] [RULE12]
				next_uc_flag[g] = trip_uc | (uc_flag_out[g] & ~clear_faults_in); // [RULE2] [RULE3] [RULE9]
				next_enable[g]  = (next_state == fault_action_pkg::ST_RUN) & ~trip_oc & ~trip_uc & allowed;
			end
		end
	endgenerate

	// Delay field of the byte that governs a retrying page; overcurrent wins when both are armed.
	function automatic logic [2:0] oc_or_uc_delay(input int p);
		if (decode_retry(oc_action[p])) begin
			oc_or_uc_delay = oc_action[p][fault_action_pkg::DELAY_MSB:fault_action_pkg::DELAY_LSB];
		end else begin
			oc_or_uc_delay = uc_action[p][fault_action_pkg::DELAY_MSB:fault_action_pkg::DELAY_LSB];
		end
	endfunction : oc_or_uc_delay

	// True when a byte selects continuous retry.
	function automatic logic decode_retry(input logic [7:0] act);
		decode_retry = (fault_action_pkg::decode_action(act) == fault_action_pkg::ACT_RETRY);
	endfunction : decode_retry

	// Registers flags, output enables and the active-low alert.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			oc_flag_out       <= '0;
			uc_flag_out       <= '0;
			output_enable_out <= '0;
			bus_alert_out     <= 1'b1;
		end else begin
			oc_flag_out       <= next_oc_flag;
			uc_flag_out       <= next_uc_flag;
			output_enable_out <= next_enable;
			bus_alert_out     <= ~(|next_oc_flag | |next_uc_flag); // [RULE1]
		end
	end

endmodule : current_fault_response_ctrl

// ---- testbench/current_fault_response_ctrl_asserts.sv ----
// Checker of port relations of the current fault response control; trip and enable checks cover page 0.
// Assumes a bind into the control block; reset pulses last more than one edge.
`timescale 1ns/1ps
module current_fault_response_ctrl_asserts #(
	parameter int PAGES = 2
) (
	input wire logic             sys_clk_in,
	input wire logic             rst_n_in,
	input wire logic [7:0]       cmd_code_in,
	input wire logic             wr_en_in,
	input wire logic             write_protect_in,
	input wire logic             clear_faults_in,
	input wire logic [PAGES-1:0] oc_fault_in,
	input wire logic [PAGES-1:0] uc_fault_in,
	input wire logic [PAGES-1:0] on_command_in,
	input wire logic             bias_ok_in,
	input wire logic [PAGES-1:0] other_shutdown_in,
	input wire logic             wr_refused_out,
	input wire logic [PAGES-1:0] oc_flag_out,
	input wire logic [PAGES-1:0] uc_flag_out,
	input wire logic [PAGES-1:0] output_enable_out,
	input wire logic             bus_alert_out
);
	// ----------------------------------------------------------------
	// Relations between fault inputs, flags, enable and alert, and refusal of protected writes
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Page 0 is allowed to run, and a command addresses an action byte.
	wire logic ok0 = on_command_in[0] && bias_ok_in && !other_shutdown_in[0];
	wire logic act_cmd = cmd_code_in == fault_action_pkg::OC_ACTION_CODE
		|| cmd_code_in == fault_action_pkg::UC_ACTION_CODE;
	// All status flags side by side.
	wire logic [2*PAGES-1:0] flags = {oc_flag_out, uc_flag_out};
	sequence run0;
		ok0 && output_enable_out[0];
	endsequence
	alert_level_a: assert property (bus_alert_out == !(|flags))
		else $error("alert does not follow the fault flags");
	oc_trip_a: assert property (run0 ##0 oc_fault_in[0] |=> oc_flag_out[0])
		else $error("overcurrent trip left its flag clear");
	uc_trip_a: assert property (run0 ##0 uc_fault_in[0] |=> uc_flag_out[0])
		else $error("undercurrent trip left its flag clear");
	trip_off_a: assert property (run0 ##0 (oc_fault_in[0] || uc_fault_in[0]) |=> !output_enable_out[0])
		else $error("output stayed on after a trip");
	flag_hold_a: assert property ((|($past(flags) & ~flags)) |-> $past(clear_faults_in))
		else $error("a flag fell without a clear command");
	alert_rise_a: assert property ($rose(bus_alert_out) |-> $past(clear_faults_in))
		else $error("alert released without a clear command");
	stop_gate_a: assert property (!ok0 |=> !output_enable_out[0])
		else $error("output on while commanded off");
	wp_refuse_a: assert property (wr_en_in && write_protect_in && act_cmd |=> wr_refused_out)
		else $error("protected write not refused");
endmodule : current_fault_response_ctrl_asserts

// ---- testbench/fault_host_model.sv ----
// Host side model: single byte writes, reads and the clear faults command.
// Assumes requests change one time unit after a rising edge of the shared clock.
`timescale 1ns/1ps
module fault_host_model (
	input  wire logic       sys_clk_in,
	input  wire logic [7:0] rd_data_in,
	input  wire logic       rd_valid_in,
	input  wire logic       refused_in,
	output logic            page_out,
	output logic [7:0]      code_out,
	output logic            wr_en_out,
	output logic [7:0]      wr_data_out,
	output logic            rd_en_out,
	output logic            clear_out
);
	// ----------------------------------------------------------------
	// Command port tasks
	// ----------------------------------------------------------------
	// Idle levels at time zero.
	initial begin
		page_out = 1'b0;
		code_out = 8'h00;
		wr_en_out = 1'b0;
		wr_data_out = 8'h00;
		rd_en_out = 1'b0;
		clear_out = 1'b0;
	end
	// One byte write; data is inverted afterwards so a stale value never looks valid.
	task automatic wr(input logic p, input logic [7:0] c, input logic [7:0] v, output logic r);
		@(posedge sys_clk_in);
		#1;
		page_out = p;
		code_out = c;
		wr_data_out = v;
		wr_en_out = 1'b1;
		@(posedge sys_clk_in);
		#1;
		wr_en_out = 1'b0;
		wr_data_out = ~v;
		r = refused_in;
	endtask : wr
	// One byte read; the answer stands in the cycle after the strobe.
	task automatic rd(input logic p, input logic [7:0] c, output logic [7:0] v);
		@(posedge sys_clk_in);
		#1;
		page_out = p;
		code_out = c;
		rd_en_out = 1'b1;
		@(posedge sys_clk_in);
		#1;
		rd_en_out = 1'b0;
		v = rd_valid_in === 1'b1 ? rd_data_in : 8'hxx;
	endtask : rd
	// Clear faults pulse, the only way the host releases latched flags.
	task automatic clr();
		@(posedge sys_clk_in);
		#1;
		clear_out = 1'b1;
		@(posedge sys_clk_in);
		#1;
		clear_out = 1'b0;
	endtask : clr
endmodule : fault_host_model

// ---- testbench/tb_current_fault_response_ctrl.sv ----
// Testbench: action byte table, trips in follow, latched and retry modes, protection and reset.
// Assumes the host model drives the command port; fault and enable levels come from here.
`timescale 1ns/1ps
bind current_fault_response_ctrl current_fault_response_ctrl_asserts #(.PAGES(PAGES)) chk_inst (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_code_in(cmd_code_in), .wr_en_in(wr_en_in),
	.write_protect_in(write_protect_in), .clear_faults_in(clear_faults_in), .oc_fault_in(oc_fault_in),
	.uc_fault_in(uc_fault_in), .on_command_in(on_command_in), .bias_ok_in(bias_ok_in),
	.other_shutdown_in(other_shutdown_in), .wr_refused_out(wr_refused_out), .oc_flag_out(oc_flag_out),
	.uc_flag_out(uc_flag_out), .output_enable_out(output_enable_out), .bus_alert_out(bus_alert_out));
module tb_current_fault_response_ctrl;
	// ----------------------------------------------------------------
	// Signals, design, host and helpers
	// ----------------------------------------------------------------
	localparam int STEP = 10;
	typedef struct packed {logic [7:0] code; logic page; logic [7:0] data; logic [7:0] exp;} row_t;
	logic       sys_clk_in, rst_n_in, bias_ok_in, page_in, wr_en_in, rd_en_in, write_protect_in, r;
	logic       clear_faults_in, rd_valid_out, wr_refused_out, bus_alert_out;
	logic [1:0] oc_fault_in, uc_fault_in, on_command_in, other_shutdown_in;
	logic [1:0] oc_flag_out, uc_flag_out, output_enable_out;
	logic [7:0] cmd_code_in, wr_data_in, rd_data_out, d;
	int         miscompares, cmp_count, cycles, n;
	// Retry on page 0 undercurrent, follow on page 0 overcurrent, unused code on page 1 overcurrent, follow on page 1 undercurrent, unmapped code.
	row_t rows [5] = '{'{8'he6, 1'b0, 8'hb9, 8'hb9}, '{8'he5, 1'b0, 8'hff, 8'hff},
		'{8'he5, 1'b1, 8'h48, 8'h48}, '{8'he6, 1'b1, 8'hc0, 8'hc0}, '{8'he7, 1'b0, 8'h5a, 8'h00}};
	current_fault_response_ctrl #(.PAGES(2), .STEP_CYCLES(STEP)) current_fault_response_ctrl_inst (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .page_in(page_in), .cmd_code_in(cmd_code_in),
		.wr_en_in(wr_en_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in), .write_protect_in(write_protect_in),
		.clear_faults_in(clear_faults_in), .oc_fault_in(oc_fault_in), .uc_fault_in(uc_fault_in),
		.on_command_in(on_command_in), .bias_ok_in(bias_ok_in), .other_shutdown_in(other_shutdown_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .wr_refused_out(wr_refused_out),
		.oc_flag_out(oc_flag_out), .uc_flag_out(uc_flag_out), .output_enable_out(output_enable_out),
		.bus_alert_out(bus_alert_out));
	fault_host_model fault_host_model_inst (.sys_clk_in(sys_clk_in), .rd_data_in(rd_data_out),
		.rd_valid_in(rd_valid_out), .refused_in(wr_refused_out), .page_out(page_in), .code_out(cmd_code_in),
		.wr_en_out(wr_en_in), .wr_data_out(wr_data_in), .rd_en_out(rd_en_in), .clear_out(clear_faults_in));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Waits k rising edges and lets their updates settle.
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_in);
		#1;
	endtask : tick
	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	// Free running clock and a ceiling on the run length.
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	// Table rows first, then the trip modes, protection and a second reset.
	initial begin
		rst_n_in = 1'b0;
		bias_ok_in = 1'b1;
		on_command_in = 2'b11;
		oc_fault_in = 2'b00;
		uc_fault_in = 2'b00;
		other_shutdown_in = 2'b00;
		write_protect_in = 1'b0;
		tick(20);
		rst_n_in = 1'b1;
		foreach (rows[i]) fault_host_model_inst.wr(rows[i].page, rows[i].code, rows[i].data, r);
		foreach (rows[i]) begin
			fault_host_model_inst.rd(rows[i].page, rows[i].code, d);
			chk("readback", d, rows[i].exp);
		end
		oc_fault_in = 2'b01;
		tick(3);
		chk("enable", 8'(output_enable_out), 8'h02);
		chk("flags", 8'({oc_flag_out, uc_flag_out}), 8'h04);
		chk("alert", 8'(bus_alert_out), 8'h00);
		oc_fault_in = 2'b00;
		tick(2);
		chk("enable", 8'(output_enable_out), 8'h03);
		chk("flags", 8'({oc_flag_out, uc_flag_out}), 8'h04);
		oc_fault_in = 2'b10;
		tick(1);
		oc_fault_in = 2'b00;
		tick(4 * STEP);
		chk("enable", 8'(output_enable_out), 8'h01);
		chk("flags", 8'({oc_flag_out, uc_flag_out}), 8'h0c);
		fault_host_model_inst.clr();
		tick(2);
		chk("enable", 8'(output_enable_out), 8'h03);
		chk("flags", 8'({oc_flag_out, uc_flag_out}), 8'h00);
		chk("alert", 8'(bus_alert_out), 8'h01);
		uc_fault_in = 2'b01;
		tick(2);
		chk("enable", 8'(output_enable_out), 8'h02);
		chk("flags", 8'({oc_flag_out, uc_flag_out}), 8'h01);
		n = 0;
		while (output_enable_out[0] !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		n = 1;
		tick(1);
		while (output_enable_out[0] !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		// A delay field of one gives two steps between attempt starts.
		chk("retry gap", 8'(n), 8'((1 + 1) * STEP));
		other_shutdown_in = 2'b01;
		tick(3 * STEP);
		chk("enable", 8'(output_enable_out), 8'h02);
		other_shutdown_in = 2'b00;
		bias_ok_in = 1'b0;
		tick(2);
		chk("enable", 8'(output_enable_out), 8'h00);
		bias_ok_in = 1'b1;
		on_command_in = 2'b10;
		tick(3 * STEP);
		chk("enable", 8'(output_enable_out), 8'h02);
		uc_fault_in = 2'b00;
		on_command_in = 2'b11;
		write_protect_in = 1'b1;
		fault_host_model_inst.wr(1'b0, 8'he5, 8'h11, r);
		chk("refused", 8'(r), 8'h01);
		fault_host_model_inst.rd(1'b0, 8'he5, d);
		chk("protected", d, 8'hff);
		write_protect_in = 1'b0;
		rst_n_in = 1'b0;
		tick(3);
		rst_n_in = 1'b1;
		for (int i = 0; i < 4; i++) begin
			fault_host_model_inst.rd(i[0], i[1] ? 8'he6 : 8'he5, d);
			chk("reset value", d, 8'h80);
		end
		oc_fault_in = 2'b01;
		tick(1);
		oc_fault_in = 2'b00;
		tick(3 * STEP);
		chk("enable", 8'(output_enable_out), 8'h02);
		wrap_up();
	end
endmodule : tb_current_fault_response_ctrl
